//--- shared/cycle_control_code_resp_pkg.sv
/*
  constants for the cycle-control-code responder: control codes, vector
  fill value, reset values.
  assumes: used by src/cycle_control_code_responder.sv only, referenced with pkg::name.
*/
`default_nettype none
package cycle_control_code_resp_pkg;
  localparam logic [4:0] CC_LOAD_DCL = 5'h0E;
  localparam logic [4:0] CC_VEC_LO = 5'h0F;
  localparam logic [4:0] CC_LOAD_DCU = 5'h11;
  localparam logic [4:0] CC_LOAD_PCL = 5'h12;
  localparam logic [4:0] CC_PORT_VEC_HI = 5'h13;
  localparam logic [4:0] CC_LD_PCU = 5'h14;
  localparam logic [4:0] CC_LD_SRU = 5'h15;
  localparam logic [4:0] CC_LD_DCU = 5'h16;
  localparam logic [4:0] CC_LD_PCL = 5'h17;
  localparam logic [4:0] CC_LD_SRL = 5'h18;
  localparam logic [4:0] CC_LD_DCL = 5'h19;
  localparam logic [4:0] CC_PORT_READ = 5'h1B;
  localparam logic [4:0] CC_SHORT_IO = 5'h1C;
  localparam logic [4:0] CC_DRIVE_PCL = 5'h1E;
  localparam logic [4:0] CC_DRIVE_PCU = 5'h1F;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage
`default_nettype wire

//--- src/cycle_control_code_responder.sv
/*
  control-code responder of a static memory interface: holds copies of the
  program counter, stack register and data counter, drives the address lines,
  and drives or captures the data bus per the code of each instruction cycle.
  assumes: the cpu's cycle boundaries arrive as one-cycle strobes i_access1 and
  i_access2 (second access) synchronous to i_clk; the memory array, timer and
  interrupt chain live elsewhere and report i_int_source and i_port_selected.
*/
`default_nettype none
// **********************************************
// **********************************************
module cycle_control_code_responder (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [4:0] i_cycle_control_code,
  input wire logic i_access1,
  input wire logic i_access2,
  input wire logic [7:0] i_data,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_int_source,
  input wire logic i_port_selected,
  input wire logic [7:0] i_lower_vector,
  input wire logic [7:0] i_upper_vector,
  input wire logic i_short_port_input_instr,
  input wire logic i_short_port_output_instr,
  input wire logic [7:0] i_port_addr,
  input wire logic [7:0] i_port_data,
  output logic [15:0] o_addr,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_register_drive_out,
  output logic o_short_cycle,
  output logic [15:0] o_program_counter_copy,
  output logic [15:0] o_stack_register_copy,
  output logic [15:0] o_data_counter_copy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b100
  } phase_t;

  phase_t phase_q;
  logic [15:0] pc_q;
  logic [15:0] sr_q;
  logic [15:0] dc_q;
  logic short_io;
  logic src_hit;
  logic port_hit;
  logic low_port;
  logic drive_pc;

  // **********************************************
  // decode helpers
  // **********************************************
  // codes on which the interrupt source answers
  function automatic logic source_code(input logic [4:0] c);
    return (c == cycle_control_code_resp_pkg::CC_VEC_LO) || (c == cycle_control_code_resp_pkg::CC_PORT_READ);
  endfunction

  // codes on which an owned port answers
  function automatic logic port_code(input logic [4:0] c);
    return (c == cycle_control_code_resp_pkg::CC_PORT_VEC_HI) || (c == cycle_control_code_resp_pkg::CC_PORT_READ);
  endfunction

  function automatic logic [15:0] vector_value(input logic src);
    // interrupt source wins over port ownership when both claim the cycle
    if (src) begin
      return {cycle_control_code_resp_pkg::ALL_ONES, i_lower_vector};
    end
    return {i_upper_vector, cycle_control_code_resp_pkg::ALL_ONES};
  endfunction

  assign short_io = i_short_port_input_instr | i_short_port_output_instr;
  // each code only listens to its own claimant, a stray claim must not drive
  assign src_hit = i_int_source && source_code(i_cycle_control_code);
  assign port_hit = i_port_selected && port_code(i_cycle_control_code);
  assign low_port = i_port_addr[7:1] == 7'h00;
  assign drive_pc = (i_cycle_control_code == cycle_control_code_resp_pkg::CC_DRIVE_PCL)
    || (i_cycle_control_code == cycle_control_code_resp_pkg::CC_DRIVE_PCU);

  // **********************************************
  // access phase tracking
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase_q <= ST_IDLE;
    end else if (i_access2) begin
      phase_q <= ST_SECOND;
    end else if (i_access1) begin
      phase_q <= ST_FIRST;
    end
  end

  // **********************************************
  // program counter copy
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pc_q <= cycle_control_code_resp_pkg::PC_RESET;
    end else if (i_access2) begin
      unique case (i_cycle_control_code)
        cycle_control_code_resp_pkg::CC_LOAD_PCL: pc_q[7:0] <= i_data;
        cycle_control_code_resp_pkg::CC_LD_PCU: pc_q[15:8] <= i_data;
        cycle_control_code_resp_pkg::CC_LD_PCL: pc_q[7:0] <= i_data;
        default: begin
        end
      endcase
    end
  end

  // **********************************************
  // stack register copy
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sr_q <= cycle_control_code_resp_pkg::PC_RESET;
    end else if (i_access2) begin
      unique case (i_cycle_control_code)
        cycle_control_code_resp_pkg::CC_LD_SRU: sr_q[15:8] <= i_data;
        cycle_control_code_resp_pkg::CC_LD_SRL: sr_q[7:0] <= i_data;
        default: begin
        end
      endcase
    end
  end

  // **********************************************
  // data counter copy
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dc_q <= cycle_control_code_resp_pkg::PC_RESET;
    end else if (i_access2) begin
      unique case (i_cycle_control_code)
        cycle_control_code_resp_pkg::CC_LOAD_DCL: dc_q[7:0] <= i_mem_rdata;
        cycle_control_code_resp_pkg::CC_LOAD_DCU: dc_q[15:8] <= i_mem_rdata;
        cycle_control_code_resp_pkg::CC_LD_DCU: dc_q[15:8] <= i_data;
        cycle_control_code_resp_pkg::CC_LD_DCL: dc_q[7:0] <= i_data;
        default: begin
        end
      endcase
    end
  end

  // **********************************************
  // address lines
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_addr <= cycle_control_code_resp_pkg::PC_RESET;
    end else if (i_access1) begin
      o_addr <= pc_q;
    end else if (i_access2) begin
      if (src_hit || port_hit) begin
        o_addr <= vector_value(src_hit);
      end else begin
        o_addr <= pc_q;
      end
    end
  end

  // **********************************************
  // data bus value
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_data <= cycle_control_code_resp_pkg::BYTE_RESET;
    end else if (i_access2) begin
      if (i_cycle_control_code == cycle_control_code_resp_pkg::CC_DRIVE_PCL) begin
        o_data <= pc_q[7:0];
      end else if (i_cycle_control_code == cycle_control_code_resp_pkg::CC_DRIVE_PCU) begin
        o_data <= pc_q[15:8];
      end else if (i_cycle_control_code == cycle_control_code_resp_pkg::CC_SHORT_IO && short_io) begin
        if (low_port && i_port_selected) begin
          o_data <= i_port_data;
        end else if (!low_port) begin
          // the cpu places the port address itself; only track it here
          o_data <= i_port_addr;
        end
      end
    end
  end

  // **********************************************
  // data bus enable
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_data_oe <= 1'b0;
    end else if (i_access1) begin
      // first access never drives the bus
      o_data_oe <= 1'b0;
    end else if (i_access2) begin
      o_data_oe <= drive_pc || (i_cycle_control_code == cycle_control_code_resp_pkg::CC_SHORT_IO
        && i_short_port_input_instr && low_port && i_port_selected);
    end
  end

  // **********************************************
  // register drive output
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_register_drive_out <= 1'b0;
    end else if (i_access1) begin
      o_register_drive_out <= 1'b0;
    end else if (i_access2) begin
      o_register_drive_out <= src_hit || port_hit || drive_pc;
    end
  end

  // **********************************************
  // short cycle flag
  // **********************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_short_cycle <= 1'b0;
    end else if (i_access1) begin
      o_short_cycle <= 1'b0;
    end else if (i_access2) begin
      o_short_cycle <= (i_cycle_control_code == cycle_control_code_resp_pkg::CC_SHORT_IO) && !short_io;
    end
  end

  assign o_program_counter_copy = pc_q;
  assign o_stack_register_copy = sr_q;
  assign o_data_counter_copy = dc_q;
endmodule
`default_nettype wire

//--- bench/cycle_control_code_chk.sv
/* checker for cycle_control_code_responder port timing
   assumes one clock, sync reset active high */
`default_nettype none
module cycle_control_code_chk (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [4:0] i_cycle_control_code,
  input wire logic i_access2,
  input wire logic [7:0] i_data,
  input wire logic i_int_source,
  input wire logic i_port_selected,
  input wire logic [15:0] o_addr,
  input wire logic [7:0] o_data,
  input wire logic o_register_drive_out,
  input wire logic [15:0] o_program_counter_copy
);
  wire [4:0] c = i_cycle_control_code;
  wire a = i_access2;
  wire [15:0] pc = o_program_counter_copy;
  wire d = o_register_drive_out;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ****
  // rules
  // ****
  property p_pcl; a && c == 5'h12 |=> pc[7:0] == $past(i_data); endproperty
  a_pcl: assert property (p_pcl) else $error("pc low");
  property p_pcu; a && c == 5'h14 |=> pc[15:8] == $past(i_data); endproperty
  a_pcu: assert property (p_pcu) else $error("pc high");
  property p_vec; a && c == 5'h0F && i_int_source |=> d && o_addr[15:8] == 8'hFF; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_prt; a && c == 5'h13 && i_port_selected |=> d && o_addr[7:0] == 8'hFF; endproperty
  a_prt: assert property (p_prt) else $error("port");
  property p_nod; a && c inside {5'h0F, 5'h13, 5'h1B} && !i_int_source && !i_port_selected |=> !d; endproperty
  a_nod: assert property (p_nod) else $error("drive");
  property p_pco; a && c == 5'h1E |=> d && o_data == pc[7:0]; endproperty
  a_pco: assert property (p_pco) else $error("out low");
  property p_pch; a && c == 5'h1F |=> d && o_data == pc[15:8] && $stable(pc); endproperty
  a_pch: assert property (p_pch) else $error("out high");
  property p_adr; a && c == 5'h1A |=> o_addr == $past(pc); endproperty
  a_adr: assert property (p_adr) else $error("address");
endmodule
bind cycle_control_code_responder cycle_control_code_chk chk (.*);
`default_nettype wire

//--- bench/cpu_model.sv
/* cpu side: one code per request, first then second access strobe
   assumes requests at rising edges, one in flight */
`default_nettype none
module cpu_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [4:0] i_code,
  input wire logic [7:0] i_byte,
  output logic [4:0] o_code,
  output logic o_acc1,
  output logic o_acc2,
  output logic [7:0] o_data
);
  logic [1:0] ph_q = 2'h0;
  initial {o_code, o_acc1, o_acc2, o_data} = '0;
  // released bus toggles so a stale byte never matches
  always @(negedge i_clk) begin
    o_acc1 <= i_go && ph_q == 2'h0;
    o_acc2 <= ph_q == 2'h1;
    o_data <= ph_q == 2'h1 ? i_byte : ~o_data;
    if (i_go && ph_q == 2'h0) o_code <= i_code;
    ph_q <= ph_q == 2'h1 ? 2'h2 : {1'b0, i_go && ph_q == 2'h0};
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
/* bench: cpu model issues codes, copies and buses are checked
   assumes responder, checker and cpu model compiled first */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_srst = 1, go = 0, i_access1, i_access2, o_data_oe, o_register_drive_out, o_short_cycle;
  logic i_int_source, i_port_selected, i_short_port_input_instr, i_short_port_output_instr;
  logic [4:0] i_cycle_control_code, cc = '0;
  logic [7:0] i_data, i_lower_vector, i_upper_vector, i_port_addr, i_port_data, o_data, bb = '0;
  logic [15:0] o_addr, o_program_counter_copy, o_stack_register_copy, o_data_counter_copy;
  logic [47:0] s = '0;
  logic [31:0] seed = 32'h73BF0500;
  int err_count = 0, num_checks = 0, cyc = 0;
  wire logic [7:0] i_mem_rdata = 8'h00;
  cycle_control_code_responder uut (.*);
  cpu_model cpu (.i_clk, .i_go(go), .i_code(cc), .i_byte(bb), .o_code(i_cycle_control_code),
    .o_acc1(i_access1), .o_acc2(i_access2), .o_data(i_data));
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc == 1000) begin
    err_count++;
    final_report();
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic op(input logic [4:0] c, input logic [7:0] b, input logic [7:0] pa, input logic [3:0] f);
    logic v, u;
    logic [15:0] ea;
    @(negedge i_clk);
    seed = xs(seed);
    {i_lower_vector, i_upper_vector, i_port_data} = seed[23:0];
    {i_short_port_output_instr, i_short_port_input_instr, i_port_selected, i_int_source} = f;
    i_port_addr = pa;
    @(posedge i_clk) {go, cc, bb} <= {1'b1, c, b};
    @(posedge i_clk) go <= 1'b0;
    repeat (2) @(negedge i_clk);
    v = f[0] && c inside {5'h0F, 5'h1B};
    u = f[1] && c inside {5'h13, 5'h1B};
    ea = v ? {8'hFF, i_lower_vector} : u ? {i_upper_vector, 8'hFF} : s[47:32];
    chk(o_register_drive_out, v || u || c[4:1] == 4'hF);
    if (c == 5'h12 || c inside {[5'h14:5'h19]}) s[c == 5'h12 ? 39 : 47 - 16 * ((c - 20) % 3) - 8 * (c > 22) -: 8] = b;
    else chk(o_addr, ea);
    chk({o_program_counter_copy, o_stack_register_copy, o_data_counter_copy}, s);
    if (c[4:1] == 4'hF) chk(o_data, c[0] ? s[47:40] : s[39:32]);
    if (c == 5'h1C) chk(o_short_cycle, f[3:2] == 2'b00);
    chk(o_data_oe, c[4:1] == 4'hF || (c == 5'h1C && f[2] && f[1] && pa < 2));
    if (c == 5'h1C && f[3:2] && pa > 1) chk(o_data, pa);
    if (c == 5'h1C && f[2] && f[1] && pa < 2) chk(o_data, i_port_data);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {i_int_source, i_port_selected, i_short_port_input_instr, i_short_port_output_instr, i_port_addr} = '0;
    {i_lower_vector, i_upper_vector, i_port_data} = '0;
    repeat (3) @(negedge i_clk);
    i_srst = 0;
    for (int f = 0; f < 4; f++) for (int k = 0; k < 3; k++) op(k == 0 ? 5'h0F : k == 1 ? 5'h13 : 5'h1B, 8'h00, 8'h00, 4'(f));
    op(5'h1C, 8'h00, 8'h01, 4'b0110);
    $display("end of vector tests");
    repeat (60) begin
      seed = xs(seed);
      op(5'h12 + 5'(seed[7:0] % 14), seed[15:8], 8'(seed[17:16]), seed[23:20]);
    end
    $display("end of random tests");
    final_report();
  end
endmodule
`default_nettype wire
